// [logic/link_maint_pkg.sv]
// package: register map, fields, reset values and carriers for the link maintenance registers
// Notes on behaviour
// - command field codes 0b011 device reset, 0b100 input status; others reserved.
// - response bits 4..0 capture link status of the latest link response.
// - response bits 9..5 capture partner_ack_tag_state of the latest link response.
// - soliciting request: valid bit 31 sets once the response fields are loaded.
// - non-soliciting request: valid bit sets once the request symbol is sent.
// - reading the response register returns the valid flag then clears it.
// - ackID bits 4..0 hold next transmit tag, reset to zero.
// - writing next transmit tag makes the port resend from that value.
// - ackID bits 12..8 hold expected acknowledge tag, software writable.
// - ackID bits 28..24 hold expected receive tag, software writable.
// - writing one to ackID bit 31 discards all unacknowledged packets.
// - the discard bit always reads zero.
// - error status bit 8 shows input stopped on error.
// - error status bit 10 shows input stopped in retry.
// - error status bit 16 shows output stopped on error.
// - bit 18 shows output stopped in retry; bit 19 shows output retried.
// - bit 9 latches an input error until software writes one.
// - bits 17, 20 and 2 latch output error, output retry, port error; write one clears.
// - control bit 0 reads one for serial port, also after reset.
// - control bits 11..4 are a writable resend suppress mask, reset zero.
package link_maint_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_REQ = 12'h140;
  localparam logic [11:0] OFS_RESP = 12'h144;
  localparam logic [11:0] OFS_ACKID = 12'h148;
  localparam logic [11:0] OFS_ERR = 12'h158;
  localparam logic [11:0] OFS_CTRL = 12'h15C;
  localparam logic [2:0] CMD_RESET_DEV = 3'h3;
  localparam logic [2:0] CMD_INPUT_STATUS = 3'h4;
  localparam int RESP_LSTAT_LSB = 0;
  localparam int RESP_ASTAT_LSB = 5;
  localparam int RESP_VALID_BIT = 31;
  localparam int ACK_TX_LSB = 0;
  localparam int ACK_EXP_LSB = 8;
  localparam int ACK_RX_LSB = 24;
  localparam int ACK_DISCARD_BIT = 31;
  localparam int ERR_PORT_ERR_BIT = 2;
  localparam int ERR_IN_STOP_BIT = 8;
  localparam int ERR_IN_SEEN_BIT = 9;
  localparam int ERR_IN_RETRY_BIT = 10;
  localparam int ERR_OUT_STOP_BIT = 16;
  localparam int ERR_OUT_SEEN_BIT = 17;
  localparam int ERR_OUT_RETRY_BIT = 18;
  localparam int ERR_OUT_RETRIED_BIT = 19;
  localparam int ERR_OUT_RTY_SEEN_BIT = 20;
  localparam int CTRL_TYPE_BIT = 0;
  localparam int CTRL_MASK_LSB = 4;
  localparam logic [4:0] TAG_RESET = 5'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic CTRL_TYPE_SERIAL = 1'b1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    logic [4:0] link_status;
    logic [4:0] ack_status;
  } link_resp_t;

  typedef struct packed {
    logic in_err_stop;
    logic in_retry_stop;
    logic out_err_stop;
    logic out_retry_stop;
    logic out_retried;
    logic in_err_evt;
    logic out_err_evt;
    logic out_retry_evt;
    logic port_err_evt;
  } port_events_t;

  typedef struct packed {
    logic valid;
    logic [4:0] value;
  } tag_load_t;
endpackage

// [logic/sticky_bits.sv]
// module: set-wins sticky flags with write-one-to-clear
`timescale 1ns/100ps
module sticky_bits #(
  parameter int N = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] flags
);
  typedef struct packed {
    logic [N-1:0] f;
  } sticky_state_t;
  sticky_state_t st_reg;
  sticky_state_t st_next;

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < N; i++) begin
      // set beats clear so an event in the clear cycle survives
      if (set[i]) begin
        st_next.f[i] = 1'b1;
      end else if (clr[i]) begin
        st_next.f[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.f;

  a_set_wins: assert property (@(posedge mclk) disable iff (!rst_n)
    (|set) |=> ((flags & $past(set)) == $past(set)))
    else $error("sticky flag lost its set");
  a_clear_only: assert property (@(posedge mclk) disable iff (!rst_n)
    ((|(clr & ~set)) ##1 1'b1) |-> ((flags & $past(clr & ~set)) == '0))
    else $error("sticky flag not cleared");
endmodule

// [logic/link_req_sender.sv]
// module: issues link-request symbols and tracks the response-valid flag
`timescale 1ns/100ps
module link_req_sender
  import link_maint_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmd_wr,
  input wire logic [2:0] cmd_code,
  input wire logic sym_ready,
  input wire link_maint_pkg::link_resp_t resp_in,
  input wire logic resp_rd,
  output logic sym_valid,
  output logic [2:0] sym_cmd,
  output logic resp_valid,
  output logic [4:0] link_status,
  output logic [4:0] ack_status
);
  import link_maint_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SEND = 2'b01,
    S_WAIT = 2'b10
  } req_state_t;

  typedef struct packed {
    req_state_t st;
    logic [2:0] cmd;
    logic valid;
    logic [4:0] lstat;
    logic [4:0] astat;
  } sender_state_t;
  sender_state_t s_reg;
  sender_state_t s_next;
  logic cmd_ok;
  logic set_valid;

  // both defined commands start a request; only input-status solicits a link response
  assign cmd_ok = (cmd_code == CMD_RESET_DEV) || (cmd_code == CMD_INPUT_STATUS);

  always_comb begin
    s_next = s_reg;
    set_valid = 1'b0;
    if (resp_in.valid) begin
      s_next.lstat = resp_in.link_status;
      s_next.astat = resp_in.ack_status;
    end
    case (s_reg.st)
      S_IDLE: begin
        if (cmd_wr && cmd_ok) begin
          s_next.st = S_SEND;
          s_next.cmd = cmd_code;
        end
      end
      S_SEND: begin
        if (sym_ready) begin
          // reset-device gets no answer from a resetting partner, so treat as unanswered
          if (s_reg.cmd == CMD_RESET_DEV) begin
            s_next.st = S_IDLE;
            set_valid = 1'b1;
          end else begin
            s_next.st = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (resp_in.valid) begin
          s_next.st = S_IDLE;
          set_valid = 1'b1;
        end
      end
      default: begin
        s_next.st = S_IDLE;
      end
    endcase
    // a new request in flight invalidates the old answer
    if (s_reg.st == S_IDLE && cmd_wr && cmd_ok) begin
      s_next.valid = 1'b0;
    end else if (set_valid) begin
      s_next.valid = 1'b1;
    end else if (resp_rd) begin
      s_next.valid = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_reg <= '{st: S_IDLE, cmd: 3'h0, valid: 1'b0, lstat: TAG_RESET, astat: TAG_RESET};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sym_valid = (s_reg.st == S_SEND);
  assign sym_cmd = s_reg.cmd;
  assign resp_valid = s_reg.valid;
  assign link_status = s_reg.lstat;
  assign ack_status = s_reg.astat;

  a_send_once: assert property (@(posedge mclk) disable iff (!rst_n)
    (sym_valid && sym_ready) |=> !sym_valid)
    else $error("request symbol sent twice");
  a_answer_valid: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_reg.st == S_WAIT && resp_in.valid) |=> (resp_valid && link_status == $past(resp_in.link_status)
      && ack_status == $past(resp_in.ack_status)))
    else $error("response valid without captured fields");
  a_reset_sent: assert property (@(posedge mclk) disable iff (!rst_n)
    (sym_valid && sym_ready && sym_cmd == CMD_RESET_DEV) |=> resp_valid)
    else $error("unanswered request did not set valid");
endmodule

// [logic/port_link_maint_csrs.sv]
// module: per-port link maintenance and status register bank
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
module port_link_maint_csrs
  import link_maint_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire link_maint_pkg::bus_req_t bus,
  output logic [31:0] rdata,
  output logic req_sym_valid,
  input wire logic req_sym_ready,
  output logic [2:0] req_sym_cmd,
  input wire link_maint_pkg::link_resp_t link_resp,
  input wire link_maint_pkg::port_events_t events,
  input wire logic tx_tag_adv,
  input wire logic ack_tag_adv,
  input wire logic rx_tag_adv,
  output logic [4:0] next_tx_tag,
  output logic [4:0] expected_ack_tag,
  output logic [4:0] expected_rx_tag,
  output logic resend_start,
  output logic [4:0] resend_from_tag,
  output logic discard_unacked_pkts,
  output logic [7:0] resend_suppress_bits,
  output logic [2:0] stop_flags
);
  import link_maint_pkg::*;

  typedef struct packed {
    logic [31:0] rdata;
    logic [4:0] tx_tag;
    logic [4:0] ack_tag;
    logic [4:0] rx_tag;
    logic resend;
    logic [4:0] resend_tag;
    logic discard;
    logic [7:0] suppress;
    logic [2:0] cmd_field;
    logic sym_valid;
    logic [2:0] sym_cmd;
    logic [2:0] stops;
  } csr_state_t;
  csr_state_t r_reg;
  csr_state_t r_next;

  logic wr_req;
  logic wr_ack;
  logic wr_err;
  logic rd_resp;
  logic [3:0] sticky_set;
  logic [3:0] sticky_clr;
  logic [3:0] sticky_q;
  logic snd_valid;
  logic [2:0] snd_cmd;
  logic resp_valid;
  logic [4:0] resp_lstat;
  logic [4:0] resp_astat;
  logic [31:0] resp_word;
  logic [31:0] ack_word;
  logic [31:0] err_word;
  logic [31:0] ctrl_word;

  assign wr_req = bus.wr && (bus.addr == OFS_REQ);
  assign wr_ack = bus.wr && (bus.addr == OFS_ACKID);
  assign wr_err = bus.wr && (bus.addr == OFS_ERR);
  assign rd_resp = bus.rd && (bus.addr == OFS_RESP);

  link_req_sender u_sender (
    .mclk(mclk),
    .rst_n(rst_n),
    .cmd_wr(wr_req),
    .cmd_code(bus.wdata[2:0]),
    .sym_ready(req_sym_ready),
    .resp_in(link_resp),
    .resp_rd(rd_resp),
    .sym_valid(snd_valid),
    .sym_cmd(snd_cmd),
    .resp_valid(resp_valid),
    .link_status(resp_lstat),
    .ack_status(resp_astat)
  );

  // order: port error, input seen, output seen, output retry seen
  assign sticky_set = {events.out_retry_evt, events.out_err_evt, events.in_err_evt, events.port_err_evt};
  assign sticky_clr = wr_err ? {bus.wdata[ERR_OUT_RTY_SEEN_BIT], bus.wdata[ERR_OUT_SEEN_BIT],
                                bus.wdata[ERR_IN_SEEN_BIT], bus.wdata[ERR_PORT_ERR_BIT]} : 4'h0;

  sticky_bits #(.N(4)) u_sticky (
    .mclk(mclk),
    .rst_n(rst_n),
    .set(sticky_set),
    .clr(sticky_clr),
    .flags(sticky_q)
  );

  always_comb begin
    resp_word = 32'h0;
    resp_word[RESP_LSTAT_LSB +: 5] = resp_lstat;
    resp_word[RESP_ASTAT_LSB +: 5] = resp_astat;
    resp_word[RESP_VALID_BIT] = resp_valid;
    ack_word = 32'h0;
    ack_word[ACK_TX_LSB +: 5] = r_reg.tx_tag;
    ack_word[ACK_EXP_LSB +: 5] = r_reg.ack_tag;
    ack_word[ACK_RX_LSB +: 5] = r_reg.rx_tag;
    ack_word[ACK_DISCARD_BIT] = 1'b0;
    err_word = 32'h0;
    err_word[ERR_PORT_ERR_BIT] = sticky_q[0];
    err_word[ERR_IN_STOP_BIT] = events.in_err_stop;
    err_word[ERR_IN_SEEN_BIT] = sticky_q[1];
    err_word[ERR_IN_RETRY_BIT] = events.in_retry_stop;
    err_word[ERR_OUT_STOP_BIT] = events.out_err_stop;
    err_word[ERR_OUT_SEEN_BIT] = sticky_q[2];
    err_word[ERR_OUT_RETRY_BIT] = events.out_retry_stop;
    err_word[ERR_OUT_RETRIED_BIT] = events.out_retried;
    err_word[ERR_OUT_RTY_SEEN_BIT] = sticky_q[3];
    ctrl_word = 32'h0;
    ctrl_word[CTRL_TYPE_BIT] = CTRL_TYPE_SERIAL;
    ctrl_word[CTRL_MASK_LSB +: 8] = r_reg.suppress;
  end

  always_comb begin
    r_next = r_reg;
    r_next.resend = 1'b0;
    r_next.discard = 1'b0;
    // counters advance with traffic; a software write takes priority
    if (tx_tag_adv) begin
      r_next.tx_tag = r_reg.tx_tag + 5'h01;
    end
    if (ack_tag_adv) begin
      r_next.ack_tag = r_reg.ack_tag + 5'h01;
    end
    if (rx_tag_adv) begin
      r_next.rx_tag = r_reg.rx_tag + 5'h01;
    end
    if (wr_req) begin
      r_next.cmd_field = bus.wdata[2:0];
    end
    if (wr_ack) begin
      r_next.tx_tag = bus.wdata[ACK_TX_LSB +: 5];
      r_next.resend = 1'b1;
      r_next.resend_tag = bus.wdata[ACK_TX_LSB +: 5];
      r_next.ack_tag = bus.wdata[ACK_EXP_LSB +: 5];
      r_next.rx_tag = bus.wdata[ACK_RX_LSB +: 5];
      // only a recovery aid; software must not use it in normal flow
      r_next.discard = bus.wdata[ACK_DISCARD_BIT];
    end
    if (bus.wr && bus.addr == OFS_CTRL) begin
      r_next.suppress = bus.wdata[CTRL_MASK_LSB +: 8];
    end
    r_next.sym_valid = snd_valid;
    r_next.sym_cmd = snd_cmd;
    r_next.stops = {events.out_err_stop | events.out_retry_stop, events.in_err_stop, events.in_retry_stop};
    r_next.rdata = 32'h0;
    if (bus.rd) begin
      case (bus.addr)
        OFS_REQ: begin
          r_next.rdata = {29'h0, r_reg.cmd_field};
        end
        OFS_RESP: begin
          r_next.rdata = resp_word;
        end
        OFS_ACKID: begin
          r_next.rdata = ack_word;
        end
        OFS_ERR: begin
          r_next.rdata = err_word;
        end
        OFS_CTRL: begin
          r_next.rdata = ctrl_word;
        end
        default: begin
          r_next.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r_reg <= '{rdata: 32'h0, tx_tag: TAG_RESET, ack_tag: TAG_RESET, rx_tag: TAG_RESET, resend: 1'b0,
                 resend_tag: TAG_RESET, discard: 1'b0, suppress: MASK_RESET, cmd_field: 3'h0,
                 sym_valid: 1'b0, sym_cmd: 3'h0, stops: 3'h0};
    end else begin
      r_reg <= r_next;
    end
  end

  // symbol handshake is one cycle behind the sender; the sender sees ready straight
  assign rdata = r_reg.rdata;
  assign req_sym_valid = r_reg.sym_valid;
  assign req_sym_cmd = r_reg.sym_cmd;
  assign next_tx_tag = r_reg.tx_tag;
  assign expected_ack_tag = r_reg.ack_tag;
  assign expected_rx_tag = r_reg.rx_tag;
  assign resend_start = r_reg.resend;
  assign resend_from_tag = r_reg.resend_tag;
  assign discard_unacked_pkts = r_reg.discard;
  assign resend_suppress_bits = r_reg.suppress;
  assign stop_flags = r_reg.stops;

  // a send of an unanswered request in the read cycle sets the flag again, so it is left out
  a_clear_on_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_resp && resp_valid && !link_resp.valid && !wr_req && !(snd_valid && req_sym_ready))
      |=> (rdata[RESP_VALID_BIT] && !resp_valid))
    else $error("response valid not cleared by read");
  a_discard_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_ack |=> (discard_unacked_pkts == $past(bus.wdata[ACK_DISCARD_BIT])))
    else $error("discard pulse mismatch");
  a_discard_reads0: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr == OFS_ACKID) |=> !rdata[ACK_DISCARD_BIT])
    else $error("discard bit read as one");
  a_resend_tag: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_ack |=> (resend_start && resend_from_tag == $past(bus.wdata[4:0]) && next_tx_tag == resend_from_tag))
    else $error("resend not started from written tag");
  a_port_serial: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr == OFS_CTRL) |=> rdata[CTRL_TYPE_BIT])
    else $error("port type not serial");
  a_in_stop_bit: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus.rd && bus.addr == OFS_ERR) |=> (rdata[ERR_IN_STOP_BIT] == $past(events.in_err_stop)
      && rdata[ERR_OUT_STOP_BIT] == $past(events.out_err_stop)))
    else $error("stop bits wrong");
endmodule

// [dv/link_partner_model.sv]
// link partner model: takes link-request symbols, answers input-status requests
`timescale 1ns/100ps
module link_partner_model
  import link_maint_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_sym_valid,
  input wire logic [2:0] req_sym_cmd,
  input wire logic slow,
  input wire logic [9:0] resp_fields,
  output logic req_sym_ready,
  output link_maint_pkg::link_resp_t link_resp,
  output int n_sym
);
  logic [2:0] cmd;
  initial begin
    req_sym_ready = 1'b0;
    link_resp = '0;
    n_sym = 0;
    forever begin
      @(posedge mclk);
      if (rst_n && req_sym_valid) begin
        cmd = req_sym_cmd;
        repeat (slow ? 3 : 0) @(posedge mclk);
        // ready held until valid drops, since valid lags the internal request
        req_sym_ready <= 1'b1;
        n_sym <= n_sym + 1;
        for (int i = 0; i < 8 && req_sym_valid; i++) @(posedge mclk);
        req_sym_ready <= 1'b0;
        if (cmd == CMD_INPUT_STATUS) begin
          repeat (slow ? 6 : 1) @(posedge mclk);
          link_resp <= '{1'b1, resp_fields[4:0], resp_fields[9:5]};
          @(posedge mclk);
          // idle fields inverted so stale capture shows up
          link_resp <= '{1'b0, ~resp_fields[4:0], ~resp_fields[9:5]};
        end
      end
    end
  end
endmodule

// [dv/tb.sv]
// testbench for the link maintenance register bank
`timescale 1ns/100ps
module tb;
  import link_maint_pkg::*;
  logic mclk, rst_n, slow, tx_adv, ack_adv, rx_adv, sym_rdy, sym_v, rs_start, disc;
  bus_req_t bus;
  link_resp_t lresp;
  port_events_t ev;
  logic [31:0] v, e;
  logic [2:0] sym_cmd, stops;
  logic [4:0] tx_tag, ack_tag, rx_tag, from_tag, last_from, t0, t1, t2;
  logic [31:0] rdata;
  logic [7:0] mask_out;
  logic [9:0] fields, cap;
  logic [3:0] sticky;
  int mismatches, n_checks, seed, n_sym, n_start, n_disc, dexp, k;

  port_link_maint_csrs uut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .req_sym_valid(sym_v),
    .req_sym_ready(sym_rdy), .req_sym_cmd(sym_cmd), .link_resp(lresp), .events(ev), .tx_tag_adv(tx_adv),
    .ack_tag_adv(ack_adv), .rx_tag_adv(rx_adv), .next_tx_tag(tx_tag), .expected_ack_tag(ack_tag),
    .expected_rx_tag(rx_tag), .resend_start(rs_start), .resend_from_tag(from_tag),
    .discard_unacked_pkts(disc), .resend_suppress_bits(mask_out), .stop_flags(stops));
  link_partner_model partner (.mclk(mclk), .rst_n(rst_n), .req_sym_valid(sym_v), .req_sym_cmd(sym_cmd),
    .slow(slow), .resp_fields(fields), .req_sym_ready(sym_rdy), .link_resp(lresp), .n_sym(n_sym));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (rs_start === 1'b1) begin
      n_start <= n_start + 1;
      last_from <= from_tag;
    end
    if (disc === 1'b1) n_disc <= n_disc + 1;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    // read data stand in the following cycle; taken at its closing edge
    @(posedge mclk);
    d = rdata;
  endtask

  task automatic wait_sym(input int old);
    for (int i = 0; i < 40 && n_sym == old; i++) @(posedge mclk);
    if (n_sym == old) begin
      mismatches++;
      final_report();
    end
  endtask

  task automatic poll_resp(output logic [31:0] d);
    for (int i = 0; i < 30; i++) begin
      rd_reg(OFS_RESP, d);
      if (d[31] === 1'b1) return;
    end
    mismatches++;
    final_report();
  endtask

  function automatic logic [31:0] err_exp(port_events_t x, logic [3:0] s);
    logic [31:0] r;
    r = '0;
    r[ERR_IN_STOP_BIT] = x.in_err_stop;
    r[ERR_IN_RETRY_BIT] = x.in_retry_stop;
    r[ERR_OUT_STOP_BIT] = x.out_err_stop;
    r[ERR_OUT_RETRY_BIT] = x.out_retry_stop;
    r[ERR_OUT_RETRIED_BIT] = x.out_retried;
    r[ERR_IN_SEEN_BIT] = s[0];
    r[ERR_OUT_SEEN_BIT] = s[1];
    r[ERR_OUT_RTY_SEEN_BIT] = s[2];
    r[ERR_PORT_ERR_BIT] = s[3];
    return r;
  endfunction

  initial begin
    seed = 32'h47B213F7;
    mismatches = 0;
    n_checks = 0;
    n_start = 0;
    n_disc = 0;
    dexp = 0;
    cap = '0;
    rst_n = 1'b0;
    bus = '0;
    ev = '0;
    {tx_adv, ack_adv, rx_adv, slow} = 4'h0;
    fields = '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(OFS_ACKID, v);
    chk(v, 32'h0);
    rd_reg(OFS_RESP, v);
    chk(v, 32'h0);
    rd_reg(OFS_ERR, v);
    chk(v, 32'h0);
    rd_reg(12'h150, v);
    chk(v, 32'h0);
    // bit 0 written as zero must still read serial
    for (int i = 0; i < 4; i++) begin
      e = $random(seed) & 32'h00000FF0;
      wr_reg(OFS_CTRL, e);
      rd_reg(OFS_CTRL, v);
      chk(v, {e[31:1], CTRL_TYPE_SERIAL});
      chk({24'h0, mask_out}, {24'h0, e[11:4]});
    end
    // every command code, partner prompt then slow
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 8; c++) begin
        slow <= r[0];
        e = $random(seed);
        fields <= e[9:0];
        k = n_sym;
        wr_reg(OFS_REQ, {29'h0, c[2:0]});
        if (c == 3 || c == 4) begin
          wait_sym(k);
          chk({29'h0, sym_cmd}, {29'h0, c[2:0]});
          // reset-device sets valid on send; an early read here would consume it
          if (c == 4) begin
            rd_reg(OFS_RESP, v);
            chk({31'h0, v[31]}, 32'h0);
            cap = fields;
          end
          poll_resp(v);
          chk(v, {1'b1, 21'h0, cap});
          rd_reg(OFS_RESP, v);
          chk(v, {1'b0, 21'h0, cap});
        end else begin
          repeat (8) @(posedge mclk);
          chk(n_sym, k);
        end
        rd_reg(OFS_REQ, v);
        chk(v, {29'h0, c[2:0]});
      end
    end
    // tag overwrite, then counting on top of the written values
    for (int i = 0; i < 3; i++) begin
      e = $random(seed);
      {t0, t1, t2} = e[14:0];
      e = {i != 1, 2'h0, t2, 11'h0, t1, 3'h0, t0};
      dexp += e[31];
      k = n_start;
      wr_reg(OFS_ACKID, e);
      repeat (2) @(posedge mclk);
      chk(n_start, k + 1);
      chk({27'h0, last_from}, {27'h0, t0});
      chk(n_disc, dexp);
      for (int j = 0; j < 16; j++) begin
        @(posedge mclk);
        e = $random(seed);
        {tx_adv, ack_adv, rx_adv} <= e[2:0];
        t0 += e[2];
        t1 += e[1];
        t2 += e[0];
      end
      @(posedge mclk);
      {tx_adv, ack_adv, rx_adv} <= 3'h0;
      rd_reg(OFS_ACKID, v);
      chk(v, {3'h0, t2, 11'h0, t1, 3'h0, t0});
      chk({17'h0, tx_tag, ack_tag, rx_tag}, {17'h0, t0, t1, t2});
    end
    // live stop levels beside sticky flags cleared by writing ones
    sticky = '0;
    for (int i = 0; i < 12; i++) begin
      e = $random(seed);
      ev <= e[8:0];
      @(posedge mclk);
      ev <= {e[8:4], 4'h0};
      sticky = sticky | {e[0], e[1], e[2], e[3]};
      rd_reg(OFS_ERR, v);
      chk(v, err_exp(port_events_t'({e[8:4], 4'h0}), sticky));
      chk({29'h0, stops}, {29'h0, e[6] | e[5], e[8], e[7]});
      e = $random(seed);
      wr_reg(OFS_ERR, e);
      sticky = sticky & ~{e[2], e[20], e[17], e[9]};
    end
    // event and write-one clear in one cycle: the event must survive
    @(posedge mclk);
    bus <= '{addr: OFS_ERR, wdata: 32'hFFFFFFFF, wr: 1'b1, rd: 1'b0};
    ev <= 9'h00F;
    @(posedge mclk);
    bus.wr <= 1'b0;
    ev <= '0;
    rd_reg(OFS_ERR, v);
    chk(v, err_exp('0, 4'hF));
    wr_reg(OFS_ERR, 32'hFFFFFFFF);
    rd_reg(OFS_ERR, v);
    chk(v, 32'h0);
    final_report();
  end
endmodule
